// ---- hw/eatc_pkg.sv ----
package eatc_pkg;

  // Unit count and bus widths
  localparam int UNITS = 2;
  localparam int ADR_W = 16;

  // Register word indices; byte address is four times the index
  localparam logic [13:0] IDX_CTRL_A_U1 = 14'h1fc0;
  localparam logic [13:0] IDX_CTRL_B_U1 = 14'h1fc1;
  localparam logic [13:0] IDX_PERIOD_U1 = 14'h1fc2;
  localparam logic [13:0] IDX_STATUS_U1 = 14'h1fc8;
  localparam logic [13:0] IDX_MASK_U1 = 14'h1fc9;
  localparam logic [13:0] IDX_CTRL_A_U2 = 14'h1ff0;
  localparam logic [13:0] IDX_CTRL_B_U2 = 14'h1ff1;
  localparam logic [13:0] IDX_PERIOD_U2 = 14'h1ff2;
  localparam logic [13:0] IDX_STATUS_U2 = 14'h1ff8;
  localparam logic [13:0] IDX_MASK_U2 = 14'h1ff9;

  // Bit positions of calc_control_b
  localparam int CB_START = 3;
  localparam int CB_BUSY = 2;
  localparam int CB_SYNC_DIS = 1;
  localparam int CB_IRQ_SEL = 0;

  // Bit positions of the interrupt status and mask registers
  localparam int ST_ANGLE = 0;
  localparam int ST_CALC = 1;
  localparam int ST_W = 2;

  // Reset values
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [15:0] PERIOD_RST = 16'h0010;

  // Timing and geometry of the angle timer and the calculation
  localparam int PRESC_W = 6;
  localparam int PRESC_BASE_LOG = 3;
  localparam int ANGLE_W = 9;
  localparam logic [8:0] ANGLE_LAST = 9'h17f;
  localparam logic [8:0] ANGLE_HALF = 9'h0c0;
  localparam logic [8:0] PHASE_THIRD = 9'h080;
  localparam logic [11:0] BASE_PERIOD_MIN = 12'h010;
  localparam int STEP_W = 13;
  localparam int CALC_CYCLES = 8;

  // Control register A layout, bit 7 down to bit 0
  typedef struct packed {
    logic count_direction;
    logic phase_order_select;
    logic [1:0] timer_clock_select;
    logic modulation_select;
    logic result_transfer_enable;
    logic waveform_calc_enable;
    logic angle_timer_enable;
  } eatc_ctrl_a_t;

  // Period setting layout
  typedef struct packed {
    logic [3:0] period_correction_count;
    logic [11:0] base_period;
  } eatc_period_t;

  // Result handed to the compare registers of the PWM generator
  typedef struct packed {
    logic wr;
    logic [8:0] u_phase_compare;
    logic [8:0] v_phase_compare;
    logic [8:0] w_phase_compare;
    logic [2:0] negative;
  } eatc_cmp_t;

  // Register kinds found by the address decoder
  typedef enum logic [2:0] {
    K_NONE,
    K_CTRL_A,
    K_CTRL_B,
    K_PERIOD,
    K_STATUS,
    K_MASK
  } eatc_kind_t;

endpackage

// ---- hw/eatc_calc.sv ----
`timescale 1ns/1ps
`default_nettype none
module eatc_calc
  import eatc_pkg::*;
#(
  parameter int CYCLES = CALC_CYCLES
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [8:0] angle_i,
  input wire logic three_phase_i,
  input wire logic phase_lag_i,
  output logic busy_o,
  output logic done_o,
  output logic [8:0] u_o,
  output logic [8:0] v_o,
  output logic [8:0] w_o,
  output logic [2:0] neg_o
);

  typedef struct packed {
    logic busy;
    logic done;
    logic [7:0] cnt;
    logic [8:0] u;
    logic [8:0] v;
    logic [8:0] w;
    logic [2:0] neg;
  } eatc_calc_st_t;

  eatc_calc_st_t st;
  eatc_calc_st_t next_st;

  // Angle plus or minus an offset, modulo one electrical turn
  function automatic logic [8:0] shift_angle(input logic [8:0] a,
                                             input logic [8:0] d,
                                             input logic lag);
    logic [9:0] s;
    s = 10'h000;
    if (lag)
      s = (a >= d) ? {1'b0, a - d} : {1'b0, a} + {1'b0, ANGLE_LAST} + 10'h001 - {1'b0, d};
    else
      s = {1'b0, a} + {1'b0, d};
    if (s > {1'b0, ANGLE_LAST})
      s = s - {1'b0, ANGLE_LAST} - 10'h001;
    return s[8:0];
  endfunction

  // Second half of the turn takes the minus sign under 3-phase
  function automatic logic neg_half(input logic [8:0] a, input logic tp);
    return tp && (a >= ANGLE_HALF);
  endfunction

  // Start latches the phase angles, counts the fixed latency, then ends
  always_comb
  begin
    logic [8:0] pv;
    logic [8:0] pw;
    pv = shift_angle(angle_i, PHASE_THIRD, phase_lag_i);
    pw = shift_angle(angle_i, PHASE_THIRD << 1, phase_lag_i);
    next_st = st;
    next_st.done = 1'b0;
    if (st.busy)
    begin
      if (st.cnt == 8'h00)
      begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end
      else
        next_st.cnt = st.cnt - 8'h01;
    end
    else if (start_i)
    begin
      next_st.busy = 1'b1;
      next_st.cnt = 8'(CYCLES - 1);
      next_st.u = angle_i;
      next_st.v = pv;
      next_st.w = pw;
      next_st.neg = {neg_half(angle_i, three_phase_i),
                     neg_half(pv, three_phase_i),
                     neg_half(pw, three_phase_i)};
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign busy_o = st.busy;
  assign done_o = st.done;
  assign u_o = st.u;
  assign v_o = st.v;
  assign w_o = st.w;
  assign neg_o = st.neg;

endmodule
`default_nettype wire

// ---- hw/eatc_top.sv ----
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module eatc_top
  import eatc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic irq_o,
  output eatc_cmp_t [UNITS-1:0] cmp_o
);

  typedef struct packed {
    eatc_ctrl_a_t ctrl_a;
    logic sync_start_disable;
    logic irq_source_select;
    eatc_period_t period;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic [PRESC_W-1:0] presc;
    logic [STEP_W-1:0] step_cnt;
    logic [3:0] step_idx;
    logic [ANGLE_W-1:0] angle_value;
  } eatc_unit_t;

  typedef struct packed {
    eatc_unit_t [UNITS-1:0] unit;
    logic ack;
    logic [31:0] dat;
    eatc_cmp_t [UNITS-1:0] cmp;
    logic irq;
  } eatc_state_t;

  eatc_state_t st;
  eatc_state_t next_st;

  logic [UNITS-1:0] calc_start;
  logic [UNITS-1:0] calc_busy;
  logic [UNITS-1:0] calc_done;
  logic [8:0] res_u [UNITS];
  logic [8:0] res_v [UNITS];
  logic [8:0] res_w [UNITS];
  logic [2:0] res_neg [UNITS];

  // Finds the register kind addressed by a word index
  function automatic eatc_kind_t kind_of(input logic [13:0] idx,
                                         output logic unit);
    unit = 1'b0;
    kind_of = K_NONE;
    unique case (idx)
      IDX_CTRL_A_U1: kind_of = K_CTRL_A;
      IDX_CTRL_B_U1: kind_of = K_CTRL_B;
      IDX_PERIOD_U1: kind_of = K_PERIOD;
      IDX_STATUS_U1: kind_of = K_STATUS;
      IDX_MASK_U1: kind_of = K_MASK;
      IDX_CTRL_A_U2:
      begin
        kind_of = K_CTRL_A;
        unit = 1'b1;
      end
      IDX_CTRL_B_U2:
      begin
        kind_of = K_CTRL_B;
        unit = 1'b1;
      end
      IDX_PERIOD_U2:
      begin
        kind_of = K_PERIOD;
        unit = 1'b1;
      end
      IDX_STATUS_U2:
      begin
        kind_of = K_STATUS;
        unit = 1'b1;
      end
      IDX_MASK_U2:
      begin
        kind_of = K_MASK;
        unit = 1'b1;
      end
      default: kind_of = K_NONE;
    endcase
  endfunction

  // Prescaler tick: low (3 + select) bits of the counter all ones
  function automatic logic presc_tick(input logic [PRESC_W-1:0] p,
                                      input logic [1:0] sel);
    logic [PRESC_W-1:0] m;
    m = PRESC_W'((7'h01 << (PRESC_BASE_LOG + int'(sel))) - 7'h01);
    return (p & m) == m;
  endfunction

  // Prescaler ticks in the current angle step, with m held at its floor
  function automatic logic [STEP_W-1:0] step_len(input eatc_period_t p,
                                                 input logic [3:0] idx);
    logic [11:0] m;
    m = (p.base_period < BASE_PERIOD_MIN) ? BASE_PERIOD_MIN
                                          : p.base_period;
    return {1'b0, m} + ((idx < p.period_correction_count)
                        ? 13'h0001 : 13'h0000);
  endfunction

  // Calculation engines, one per motor unit
  for (genvar g = 0; g < UNITS; g++)
  begin : g_unit
    eatc_calc #(
      .CYCLES(CALC_CYCLES)
    ) u_calc (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(calc_start[g]),
      .angle_i(st.unit[g].angle_value),
      .three_phase_i(st.unit[g].ctrl_a.modulation_select),
      .phase_lag_i(st.unit[g].ctrl_a.phase_order_select),
      .busy_o(calc_busy[g]),
      .done_o(calc_done[g]),
      .u_o(res_u[g]),
      .v_o(res_v[g]),
      .w_o(res_w[g]),
      .neg_o(res_neg[g])
    );
  end

  // Bus slave, angle timers, start logic, interrupts and transfers
  always_comb
  begin
    eatc_kind_t kind;
    logic bu;
    logic req;
    logic wr;
    logic tick;
    logic step_end;
    logic period_end;
    logic [15:0] wd;
    logic [ST_W-1:0] ev;
    logic [ST_W-1:0] clr;
    kind = K_NONE;
    bu = 1'b0;
    req = 1'b0;
    wr = 1'b0;
    tick = 1'b0;
    step_end = 1'b0;
    period_end = 1'b0;
    wd = 16'h0000;
    ev = '0;
    clr = '0;
    next_st = st;
    calc_start = '0;
    kind = kind_of(adr_i[15:2], bu);
    req = cyc_i && stb_i && !st.ack;
    wr = req && we_i;
    next_st.ack = req;
    next_st.dat = 32'h0000_0000;
    wd = {sel_i[1] ? dat_i[15:8] : 8'h00, sel_i[0] ? dat_i[7:0] : 8'h00};
    next_st.irq = 1'b0;
    for (int u = 0; u < UNITS; u++)
    begin
      next_st.cmp[u].wr = 1'b0;
      clr = '0;
      // Register writes for this unit
      if (wr && bu == 1'(u))
      begin
        unique case (kind)
          K_CTRL_A:
            if (sel_i[0])
              next_st.unit[u].ctrl_a = eatc_ctrl_a_t'(wd[7:0]);
          K_CTRL_B:
            if (sel_i[0])
            begin
              next_st.unit[u].sync_start_disable = wd[CB_SYNC_DIS];
              next_st.unit[u].irq_source_select = wd[CB_IRQ_SEL];
              if (wd[CB_START] && st.unit[u].ctrl_a.waveform_calc_enable)
                calc_start[u] = 1'b1;
            end
          K_PERIOD:
          begin
            if (sel_i[0])
              next_st.unit[u].period[7:0] = wd[7:0];
            if (sel_i[1])
              next_st.unit[u].period[15:8] = wd[15:8];
          end
          K_STATUS:
            if (sel_i[0])
              clr = wd[ST_W-1:0];
          K_MASK:
            if (sel_i[0])
              next_st.unit[u].mask = wd[ST_W-1:0];
          K_NONE:
            ;
        endcase
      end
      // Register reads for this unit
      if (req && !we_i && bu == 1'(u))
      begin
        unique case (kind)
          K_CTRL_A:
            next_st.dat = {24'h00_0000, st.unit[u].ctrl_a};
          K_CTRL_B:
          begin
            next_st.dat[CB_BUSY] = calc_busy[u];
            next_st.dat[CB_SYNC_DIS] = st.unit[u].sync_start_disable;
            next_st.dat[CB_IRQ_SEL] = st.unit[u].irq_source_select;
          end
          K_PERIOD:
            next_st.dat = {16'h0000, st.unit[u].period};
          K_STATUS:
            next_st.dat = 32'(st.unit[u].status);
          K_MASK:
            next_st.dat = 32'(st.unit[u].mask);
          K_NONE:
            ;
        endcase
      end
      // Angle timer: prescaler, step counter and angle
      tick = 1'b0;
      step_end = 1'b0;
      period_end = 1'b0;
      if (!st.unit[u].ctrl_a.angle_timer_enable)
      begin
        next_st.unit[u].presc = '0;
        next_st.unit[u].step_cnt = '0;
        next_st.unit[u].step_idx = 4'h0;
        next_st.unit[u].angle_value = '0;
      end
      else
      begin
        tick = presc_tick(st.unit[u].presc,
                          st.unit[u].ctrl_a.timer_clock_select);
        next_st.unit[u].presc = st.unit[u].presc + PRESC_W'(1);
        if (tick)
        begin
          if (st.unit[u].step_cnt + 13'h0001 >=
              step_len(st.unit[u].period, st.unit[u].step_idx))
          begin
            step_end = 1'b1;
            next_st.unit[u].step_cnt = '0;
            next_st.unit[u].step_idx = st.unit[u].step_idx + 4'h1;
          end
          else
            next_st.unit[u].step_cnt = st.unit[u].step_cnt + 13'h0001;
        end
        if (step_end)
        begin
          if (st.unit[u].ctrl_a.count_direction)
          begin
            period_end = st.unit[u].angle_value == '0;
            next_st.unit[u].angle_value = period_end ? ANGLE_LAST
                : st.unit[u].angle_value - 9'h001;
          end
          else
          begin
            period_end = st.unit[u].angle_value == ANGLE_LAST;
            next_st.unit[u].angle_value = period_end ? 9'h000
                : st.unit[u].angle_value + 9'h001;
          end
        end
      end
      // Start in step with the angle
      if (step_end && !st.unit[u].sync_start_disable
          && st.unit[u].ctrl_a.waveform_calc_enable)
        calc_start[u] = 1'b1;
      // Events: angle interrupt by selected source, calculation end
      ev = '0;
      ev[ST_ANGLE] = st.unit[u].irq_source_select ? calc_done[u]
                                                  : period_end;
      ev[ST_CALC] = calc_done[u];
      next_st.unit[u].status = (st.unit[u].status & ~clr) | ev;
      if (|(next_st.unit[u].status & st.unit[u].mask))
        next_st.irq = 1'b1;
      // Copy results into the PWM compare registers
      if (calc_done[u] && st.unit[u].ctrl_a.result_transfer_enable
          && st.unit[u].ctrl_a.waveform_calc_enable)
      begin
        next_st.cmp[u].wr = 1'b1;
        next_st.cmp[u].u_phase_compare = res_u[u];
        next_st.cmp[u].v_phase_compare = res_v[u];
        next_st.cmp[u].w_phase_compare = res_w[u];
        next_st.cmp[u].negative = res_neg[u];
      end
    end
  end

  // State register with reset values
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st <= '0;
      for (int u = 0; u < UNITS; u++)
      begin
        st.unit[u].ctrl_a <= eatc_ctrl_a_t'(CTRL_A_RST);
        st.unit[u].period <= eatc_period_t'(PERIOD_RST);
      end
    end
    else
      st <= next_st;
  end

  // Outputs straight from the state register
  assign dat_o = st.dat;
  assign ack_o = st.ack;
  assign irq_o = st.irq;
  assign cmp_o = st.cmp;

endmodule
`default_nettype wire

// ---- sim/eatc_pwm_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module eatc_pwm_model
  import eatc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire eatc_cmp_t [UNITS-1:0] cmp_i,
  output var eatc_cmp_t [UNITS-1:0] duty_o,
  output var logic [UNITS-1:0][15:0] cnt_o
);
  // Compare registers load only on a transfer pulse
  always_ff @(posedge clk_i)
  begin
    for (int u = 0; u < UNITS; u++)
    begin
      if (rst_i)
      begin
        duty_o[u] <= '0;
        cnt_o[u] <= 16'h0000;
      end
      else if (cmp_i[u].wr)
      begin
        duty_o[u] <= cmp_i[u];
        cnt_o[u] <= cnt_o[u] + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// ---- sim/eatc_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module eatc_chk
  import eatc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire eatc_cmp_t [UNITS-1:0] cmp_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Phase index moved round one turn
  function automatic logic [8:0] rot(logic [8:0] a, int d);
    return 9'((a + d) % 384);
  endfunction
  // Request taken by the slave
  sequence s_take;
    cyc_i && stb_i && !ack_o;
  endsequence
  a_ack_answer: assert property (s_take |=> ack_o)
    else $error("ack missing after request");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held two cycles");
  a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  for (genvar u = 0; u < UNITS; u++)
  begin : g_unit
    wire logic wr = cmp_o[u].wr;
    wire logic [8:0] cu = cmp_o[u].u_phase_compare;
    wire logic [8:0] cv = cmp_o[u].v_phase_compare;
    wire logic [8:0] cw = cmp_o[u].w_phase_compare;
    wire logic [2:0] cn = cmp_o[u].negative;
    // A calculation separates two transfers
    sequence s_quiet;
      !wr [*7];
    endsequence
    a_wr_spacing: assert property (wr |=> s_quiet)
      else $error("transfers closer than a calculation");
    a_cmp_hold: assert property (!wr |-> $stable(cmp_o[u][29:0]))
      else $error("compare data moved without transfer");
    a_angle_range: assert property (wr |-> cu <= ANGLE_LAST)
      else $error("phase index beyond a turn");
    a_phase_offset: assert property (wr |->
      (cv == rot(cu, 128) && cw == rot(cu, 256)) ||
      (cv == rot(cu, 256) && cw == rot(cu, 128)))
      else $error("phase spacing wrong");
    a_sign_match: assert property (wr && cn != 3'h0 |->
      cn == {cu >= ANGLE_HALF, cv >= ANGLE_HALF, cw >= ANGLE_HALF})
      else $error("sign not tied to half turn");
  end
endmodule
bind eatc_top eatc_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .cmp_o(cmp_o));
`default_nettype wire

// ---- sim/eatc_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module eatc_top_tb
  import eatc_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [15:0] adr_i = 16'h0000;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic irq_o;
  eatc_cmp_t [UNITS-1:0] cmp_o;
  eatc_cmp_t [UNITS-1:0] duty;
  logic [UNITS-1:0][15:0] cnt;
  int err_total = 0;
  int samples_checked = 0;
  int ticks = 0;
  // Block and the compare registers behind it
  eatc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
    .cmp_o(cmp_o));
  eatc_pwm_model i_pwm (.clk_i(clk_i), .rst_i(rst_i), .cmp_i(cmp_o),
    .duty_o(duty), .cnt_o(cnt));
  // Clock of 100 ns
  initial forever #50 clk_i = ~clk_i;
  // Hang guard
  always @(posedge clk_i)
  begin
    ticks <= ticks + 1;
    if (ticks == 40000)
    begin
      err_total++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // One classic cycle, held until ack
  task automatic bus(input logic w, input logic [13:0] idx,
    input logic [31:0] d, output logic [31:0] q);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= 4'h3;
    adr_i <= {idx, 2'h0};
    dat_i <= d;
    // Waits for ack as long as it takes; only the hang guard ends it
    do
      @(posedge clk_i);
    while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  function automatic logic [13:0] ix(int u, int off);
    return (u == 0 ? IDX_CTRL_A_U1 : IDX_CTRL_A_U2) + 14'(off);
  endfunction
  task automatic wr(input logic [13:0] idx, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, idx, {16'h0000, d}, q);
  endtask
  task automatic rd_chk(input string what, input logic [13:0] idx,
    input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 32'h0000_0000, q);
    check(what, q, exp);
  endtask
  // Waits for the next transfer, counting cycles
  task automatic wait_wr(input int u, output int gap);
    logic [15:0] c0;
    c0 = cnt[u];
    gap = 0;
    while (cnt[u] === c0 && gap < 3000)
    begin
      @(posedge clk_i);
      gap++;
    end
    if (gap >= 3000)
      err_total++;
  endtask
  task automatic cmpx(input int u, input logic [8:0] v, input logic [8:0] w,
    input logic [2:0] n);
    check("cmp", 32'(duty[u]), {2'h1, 9'h000, v, w, n});
  endtask
  task automatic t_reset();
    for (int u = 0; u < UNITS; u++)
    begin
      rd_chk("ctrl a", ix(u, 0), 32'h0000_0000);
      rd_chk("ctrl b", ix(u, 1), 32'h0000_0000);
      rd_chk("period", ix(u, 2), 32'h0000_0010);
      rd_chk("status", ix(u, 8), 32'h0000_0000);
      rd_chk("mask", ix(u, 9), 32'h0000_0000);
    end
    rd_chk("unmapped", 14'h1fc5, 32'h0000_0000);
    wr(ix(1, 0), 16'h00a8);
    rd_chk("unit two", ix(1, 0), 32'h0000_00a8);
    rd_chk("unit one", ix(0, 0), 32'h0000_0000);
    wr(ix(1, 0), 16'h0000);
  endtask
  task automatic t_soft(input int u);
    int g;
    logic [15:0] c;
    wr(ix(u, 0), 16'h0006);
    wr(ix(u, 1), 16'h000a);
    rd_chk("busy", ix(u, 1), 32'h0000_0006);
    wait_wr(u, g);
    cmpx(u, 9'h080, 9'h100, 3'h0);
    rd_chk("idle", ix(u, 1), 32'h0000_0002);
    rd_chk("status", ix(u, 8), 32'h0000_0002);
    check("irq", irq_o, 1'h0);
    wr(ix(u, 9), 16'h0002);
    repeat (2) @(posedge clk_i);
    check("irq on", irq_o, 1'h1);
    wr(ix(u, 8), 16'h0002);
    repeat (2) @(posedge clk_i);
    check("irq off", irq_o, 1'h0);
    rd_chk("cleared", ix(u, 8), 32'h0000_0000);
    wr(ix(u, 9), 16'h0000);
    c = cnt[u];
    wr(ix(u, 1), 16'h0002);
    repeat (20) @(posedge clk_i);
    check("no start", cnt[u], c);
  endtask
  task automatic t_mode();
    int g;
    logic [15:0] c;
    wr(ix(0, 0), 16'h004e);
    wr(ix(0, 1), 16'h000a);
    wait_wr(0, g);
    cmpx(0, 9'h100, 9'h080, 3'h2);
    for (int k = 0; k < 2; k++)
    begin
      c = cnt[0];
      wr(ix(0, 0), k ? 16'h0002 : 16'h0004);
      wr(ix(0, 1), 16'h000a);
      repeat (20) @(posedge clk_i);
      check("gated", cnt[0], c);
    end
  endtask
  task automatic t_timer();
    int g;
    int sum;
    logic [8:0] a;
    logic [15:0] c;
    wr(ix(0, 1), 16'h0000);
    // Timer is stopped around every clock select change
    for (int s = 0; s < 4; s++)
    begin
      wr(ix(0, 0), 16'(6 + 16 * s));
      wr(ix(0, 0), 16'(7 + 16 * s));
      wait_wr(0, g);
      wait_wr(0, g);
      check("step", g, 128 << s);
      wr(ix(0, 0), 16'(6 + 16 * s));
    end
    wr(ix(0, 0), 16'h0006);
    wr(ix(0, 2), 16'h2010);
    wr(ix(0, 0), 16'h0007);
    wait_wr(0, g);
    sum = 0;
    for (int i = 0; i < 16; i++)
    begin
      a = duty[0].u_phase_compare;
      wait_wr(0, g);
      sum += g;
      check("up", duty[0].u_phase_compare, 9'(a + 9'h001));
    end
    check("group", sum, 2064);
    rd_chk("no wrap", ix(0, 8), 32'h0000_0002);
    wr(ix(0, 0), 16'h0006);
    wr(ix(0, 0), 16'h0087);
    wait_wr(0, g);
    a = duty[0].u_phase_compare;
    wait_wr(0, g);
    check("down", duty[0].u_phase_compare,
      9'(a == 9'h000 ? 9'h17f : a - 9'h001));
    rd_chk("wrap", ix(0, 8), 32'h0000_0003);
    wr(ix(0, 1), 16'h0002);
    repeat (20) @(posedge clk_i);
    c = cnt[0];
    repeat (400) @(posedge clk_i);
    check("sync off", cnt[0], c);
    wr(ix(0, 0), 16'h0006);
    wr(ix(0, 1), 16'h000a);
    wait_wr(0, g);
    cmpx(0, 9'h080, 9'h100, 3'h0);
    wr(ix(0, 8), 16'h0003);
    wr(ix(0, 1), 16'h0009);
    wait_wr(0, g);
    rd_chk("calc irq", ix(0, 8), 32'h0000_0003);
  endtask
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_soft(0);
    t_soft(1);
    t_mode();
    t_timer();
    close_out();
  end
endmodule
`default_nettype wire
